/* File: bus_term_device.sv */
`timescale 1ns/100ps
// processor-side bus cycle controller: runs one access at a time and
// decides normal, halt, error or retry termination
module bus_term_device
    import bus_term_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    bus_term_if.device       bus,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [31:0] req_addr,
    input  wire logic [2:0]  req_fc,
    input  wire logic [1:0]  req_size,
    input  wire logic        req_write,
    input  wire logic [31:0] req_wdata,
    input  wire logic        req_prefetch,
    input  wire logic        req_walk,
    input  wire logic        prot_fault,
    output logic             resp_valid,
    output logic [31:0]      resp_rdata,
    output logic             resp_error,
    output logic             resp_internal,
    output logic             resp_deferred,
    output logic             exc_now,
    output logic             bus_halted
);
    // ==========================================================
    // state and registers
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_LATE,
        ST_END,
        ST_RETRY
    } cyc_state_type;

    cyc_state_type state_r, state_nxt;
    result_type    res_r, res_nxt;
    logic [31:0]   addr_r, addr_nxt;
    logic [2:0]    fc_r, fc_nxt;
    logic [1:0]    size_r, size_nxt;
    logic          write_r, write_nxt;
    logic [31:0]   wdata_r, wdata_nxt;
    logic          pref_r, pref_nxt;
    logic          walk_r, walk_nxt;
    logic          as_r, as_nxt;
    logic          rv_r, rv_nxt;
    logic [31:0]   rdata_r, rdata_nxt;
    logic          rerr_r, rerr_nxt;
    logic          rint_r, rint_nxt;
    logic          rdef_r, rdef_nxt;
    logic          exc_r, exc_nxt;

    // ==========================================================
    // termination decode
    logic term;
    logic bus_err;
    logic halt;

    // all termination lines come from glue on ref_clk, so no synchroniser
    assign term = (|bus.async_ack) | bus.sync_term | bus.autovector_request; // [RULE1]
    assign bus_err = bus.bus_error_in;
    assign halt = bus.halt_line;

    // a new cycle may not start while halt is held: that is the boundary stop
    assign req_ready  = (state_r == ST_IDLE) && !halt; // [RULE22] [RULE5]
    assign bus_halted = ((state_r == ST_IDLE) || (state_r == ST_RETRY)) && halt;

    // ==========================================================
    // next-state logic
    always_comb begin
        state_nxt = state_r;
        res_nxt   = res_r;
        addr_nxt  = addr_r;
        fc_nxt    = fc_r;
        size_nxt  = size_r;
        write_nxt = write_r;
        wdata_nxt = wdata_r;
        pref_nxt  = pref_r;
        walk_nxt  = walk_r;
        rv_nxt    = 1'b0;
        rdata_nxt = rdata_r;
        rerr_nxt  = rerr_r;
        rint_nxt  = rint_r;
        rdef_nxt  = rdef_r;
        exc_nxt   = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (req_valid && req_ready) begin
                    addr_nxt  = req_addr;
                    fc_nxt    = req_fc;
                    size_nxt  = req_size;
                    write_nxt = req_write;
                    wdata_nxt = req_wdata;
                    pref_nxt  = req_prefetch;
                    walk_nxt  = req_walk;
                    res_nxt   = RES_OK;
                    if (prot_fault) begin
                        // protection fault never reaches the pins
                        rv_nxt    = 1'b1; // [RULE4]
                        rdata_nxt = RESET_DATA;
                        rerr_nxt  = 1'b1;
                        rint_nxt  = 1'b1;
                        rdef_nxt  = req_prefetch; // [RULE23]
                        exc_nxt   = !req_prefetch; // [RULE3]
                    end else begin
                        state_nxt = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                // sampled each edge while strobe is out
                if (bus_err) begin
                    // error seen before or with termination wins outright
                    res_nxt   = halt ? RES_RETRY : RES_ERR; // [RULE9] [RULE11] [RULE13] [RULE14] [RULE20]
                    state_nxt = ST_END;
                end else if (term) begin
                    rdata_nxt = bus.rdata; // [RULE17]
                    state_nxt = ST_LATE;
                end
            end
            ST_LATE: begin
                // one more sample: the N+2 window for a late error or retry
                if (bus_err) begin
                    res_nxt = halt ? RES_RETRY : RES_ERR; // [RULE9] [RULE11] [RULE20]
                end else begin
                    res_nxt = RES_OK; // [RULE7] [RULE8] [RULE12]
                end
                state_nxt = ST_END;
            end
            ST_END: begin
                if (res_r == RES_RETRY) begin
                    state_nxt = ST_RETRY; // [RULE5]
                end else begin
                    state_nxt = ST_IDLE;
                    rv_nxt    = 1'b1;
                    rerr_nxt  = (res_r == RES_ERR); // [RULE3]
                    rint_nxt  = (res_r == RES_ERR) && walk_r; // [RULE4]
                    rdef_nxt  = (res_r == RES_ERR) && pref_r; // [RULE23]
                    exc_nxt   = (res_r == RES_ERR) && !pref_r; // [RULE3] [RULE23]
                    if (res_r == RES_ERR || write_r) begin
                        rdata_nxt = RESET_DATA; // data of a failed cycle is not trusted
                    end
                end
            end
            ST_RETRY: begin
                // strobe stays off, access info kept for an identical rerun
                if (!halt) begin
                    state_nxt = ST_RUN; // [RULE21]
                    res_nxt   = RES_OK;
                end
            end
        endcase
        as_nxt = (state_nxt == ST_RUN) || (state_nxt == ST_LATE); // [RULE21]
    end

    // ==========================================================
    // registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            res_r   <= RES_OK;
            addr_r  <= 32'h0000_0000;
            fc_r    <= 3'h0;
            size_r  <= 2'h0;
            write_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            pref_r  <= 1'b0;
            walk_r  <= 1'b0;
            as_r    <= 1'b0;
            rv_r    <= 1'b0;
            rdata_r <= RESET_DATA;
            rerr_r  <= 1'b0;
            rint_r  <= 1'b0;
            rdef_r  <= 1'b0;
            exc_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            res_r   <= res_nxt;
            addr_r  <= addr_nxt;
            fc_r    <= fc_nxt;
            size_r  <= size_nxt;
            write_r <= write_nxt;
            wdata_r <= wdata_nxt;
            pref_r  <= pref_nxt;
            walk_r  <= walk_nxt;
            as_r    <= as_nxt;
            rv_r    <= rv_nxt;
            rdata_r <= rdata_nxt;
            rerr_r  <= rerr_nxt;
            rint_r  <= rint_nxt;
            rdef_r  <= rdef_nxt;
            exc_r   <= exc_nxt;
        end
    end

    // ==========================================================
    // pins and answer
    assign bus.addr_strobe = as_r;
    assign bus.addr        = addr_r;
    assign bus.fc          = fc_r;
    assign bus.size        = size_r;
    assign bus.rw          = !write_r; // high means read
    assign bus.wdata       = wdata_r;

    assign resp_valid    = rv_r;
    assign resp_rdata    = rdata_r;
    assign resp_error    = rerr_r;
    assign resp_internal = rint_r;
    assign resp_deferred = rdef_r;
    assign exc_now       = exc_r;
endmodule

/* File: bus_term_pkg.sv */
// Overview of operation
// RULE1: cycle completes only on acknowledge or sync termination
// RULE2: responder raises bus error when nobody answers
// RULE3: bus error ends cycle and starts exception
// RULE4: protection fault or table-search error is internal
// RULE5: halt steps cycles, halt plus error retries
// RULE6: responder changes termination lines on rising edges
// RULE7: acknowledge alone ends cycle, bus continues
// RULE8: early halt ends normally then suspends bus
// RULE9: async bus error up to N+2 gives exception
// RULE10: responder drops error with acknowledge, halt later
// RULE11: async error with halt up to N+2 retries
// RULE12: halt before sync termination holds off next cycle
// RULE13: sync bus error, halt negated, gives exception
// RULE14: sync error with halt retries after halt negates
// RULE15: responder releases lines after strobe negates
// RULE16: never sync and async termination together
// RULE17: sync termination sampled every edge during strobe
// RULE18: watchdog raises bus error on unpopulated space
// RULE19: error-correcting memory may ack early, then retry
// RULE20: bus error wins over acknowledge, data invalid
// RULE21: retry idles control, waits halt, reruns same access
// RULE22: halt alone stops bus at next cycle boundary
// RULE23: bus error on prefetch flagged as deferred
package bus_term_pkg;
    // responder timing, in ref_clk cycles
    localparam logic [3:0]  WAIT_STATES    = 4'h2;
    localparam logic [3:0]  TIMEOUT_CYCLES = 4'hc;
    localparam logic [3:0]  RETRY_HOLD     = 4'h3;
    // responder memory geometry
    localparam int          MEM_AW         = 4;
    localparam logic [31:0] MEM_BASE       = 32'h0000_0000;
    localparam logic [31:0] RESET_DATA     = 32'h0000_0000;

    typedef enum logic [1:0] {
        RES_OK,
        RES_ERR,
        RES_RETRY
    } result_type;

    typedef enum logic [1:0] {
        ECC_DELAY_RETRY,
        ECC_DELAY_ERROR,
        ECC_EARLY_ERROR,
        ECC_EARLY_RETRY
    } ecc_policy_type;
endpackage

/* File: bus_term_if.sv */
`timescale 1ns/100ps
// processor bus between the cycle controller and the external glue logic
interface bus_term_if;
    logic        addr_strobe;
    logic        rw;
    logic [31:0] addr;
    logic [2:0]  fc;
    logic [1:0]  size;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [1:0]  async_ack;
    logic        sync_term;
    logic        autovector_request;
    logic        bus_error_in;
    logic        halt_line;

    modport device (
        output addr_strobe, rw, addr, fc, size, wdata,
        input  rdata, async_ack, sync_term, autovector_request, bus_error_in, halt_line
    );
    modport responder (
        input  addr_strobe, rw, addr, fc, size, wdata,
        output rdata, async_ack, sync_term, autovector_request, bus_error_in, halt_line
    );
endinterface

/* File: bus_term_responder.sv */
`timescale 1ns/100ps
// glue logic: small memory with watchdog and error-correction behaviour
module bus_term_responder
    import bus_term_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           rst,
    bus_term_if.responder       bus,
    input  wire logic           cfg_sync,
    input  wire logic           ecc_fail,
    input  wire ecc_policy_type ecc_policy,
    input  wire logic           step_halt,
    output logic                timeout_event
);
    // ==========================================================
    // state and registers
    typedef enum logic [2:0] {
        RS_IDLE,
        RS_WAIT,
        RS_LATE,
        RS_HOLD,
        RS_REL
    } resp_state_type;

    resp_state_type state_r, state_nxt;
    logic [3:0]     cnt_r, cnt_nxt;
    logic           ack_r, ack_nxt;
    logic           sync_r, sync_nxt;
    logic           err_r, err_nxt;
    logic           halt_r, halt_nxt;
    logic           lhalt_r, lhalt_nxt;
    logic           step_r;
    logic           tmo_r, tmo_nxt;
    logic [31:0]    rdata_r, rdata_nxt;
    logic [31:0]    mem [0:(1 << MEM_AW) - 1];
    logic           mem_we;
    logic           hit;
    logic [MEM_AW-1:0] idx;

    assign idx = bus.addr[MEM_AW+1:2];
    assign hit = (bus.addr[31:MEM_AW+2] == MEM_BASE[31:MEM_AW+2]);

    // ==========================================================
    // next-state logic; all outputs registered so they move on rising edges
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        ack_nxt   = ack_r;
        sync_nxt  = sync_r;
        err_nxt   = err_r;
        halt_nxt  = halt_r;
        lhalt_nxt = lhalt_r;
        tmo_nxt   = 1'b0;
        rdata_nxt = rdata_r;
        mem_we    = 1'b0;
        unique case (state_r)
            RS_IDLE: begin
                cnt_nxt = 4'h0;
                if (bus.addr_strobe) begin
                    state_nxt = RS_WAIT;
                end
            end
            RS_WAIT: begin
                cnt_nxt = cnt_r + 4'h1;
                if (!hit) begin
                    if (cnt_r == TIMEOUT_CYCLES - 4'h1) begin
                        err_nxt   = 1'b1; // [RULE2] [RULE18]
                        tmo_nxt   = 1'b1;
                        state_nxt = RS_HOLD;
                    end
                end else if (cnt_r == WAIT_STATES - 4'h1) begin
                    state_nxt = RS_HOLD;
                    if (!ecc_fail || ecc_policy == ECC_EARLY_ERROR
                        || ecc_policy == ECC_EARLY_RETRY) begin
                        // exactly one kind of termination per cycle
                        ack_nxt   = !cfg_sync; // [RULE16] [RULE1]
                        sync_nxt  = cfg_sync; // [RULE16]
                        rdata_nxt = mem[idx];
                        mem_we    = !bus.rw && !ecc_fail;
                    end
                    if (ecc_fail) begin
                        unique case (ecc_policy)
                            ECC_DELAY_RETRY: begin
                                err_nxt  = 1'b1; // [RULE5]
                                halt_nxt = 1'b1;
                            end
                            ECC_DELAY_ERROR: begin
                                err_nxt = 1'b1;
                            end
                            ECC_EARLY_ERROR, ECC_EARLY_RETRY: begin
                                state_nxt = RS_LATE;
                                lhalt_nxt = (ecc_policy == ECC_EARLY_RETRY);
                            end
                        endcase
                    end
                end
            end
            RS_LATE: begin
                // one clock after the early acknowledge
                err_nxt   = 1'b1; // [RULE19]
                halt_nxt  = lhalt_r; // [RULE19]
                state_nxt = RS_HOLD;
            end
            RS_HOLD: begin
                // lines drop only once the strobe has gone
                if (!bus.addr_strobe) begin
                    ack_nxt   = 1'b0; // [RULE15] [RULE10]
                    sync_nxt  = 1'b0;
                    err_nxt   = 1'b0; // [RULE10]
                    cnt_nxt   = 4'h0;
                    state_nxt = halt_r ? RS_REL : RS_IDLE;
                end
            end
            RS_REL: begin
                // halt released after bus error, giving time to repair memory
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r == RETRY_HOLD - 4'h1) begin
                    halt_nxt  = 1'b0; // [RULE10]
                    state_nxt = RS_IDLE;
                end
            end
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= RS_IDLE;
            cnt_r   <= 4'h0;
            ack_r   <= 1'b0;
            sync_r  <= 1'b0;
            err_r   <= 1'b0;
            halt_r  <= 1'b0;
            lhalt_r <= 1'b0;
            step_r  <= 1'b0;
            tmo_r   <= 1'b0;
            rdata_r <= RESET_DATA;
        end else begin
            state_r <= state_nxt; // [RULE6]
            cnt_r   <= cnt_nxt;
            ack_r   <= ack_nxt;
            sync_r  <= sync_nxt;
            err_r   <= err_nxt;
            halt_r  <= halt_nxt;
            lhalt_r <= lhalt_nxt;
            step_r  <= step_halt; // [RULE5]
            tmo_r   <= tmo_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // memory content is not reset; reads of unwritten words are undefined
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            mem[idx] <= bus.wdata;
        end
    end

    assign bus.async_ack          = {ack_r, ack_r};
    assign bus.sync_term          = sync_r;
    assign bus.autovector_request = 1'b0;
    assign bus.bus_error_in       = err_r;
    assign bus.halt_line          = halt_r | step_r;
    assign bus.rdata              = rdata_r;
    assign timeout_event          = tmo_r;
endmodule

/* File: bus_term_props.sv */
`timescale 1ns/100ps
// ==========
// bus link checker: watches the joined interface only
module bus_term_props (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        addr_strobe,
    input wire logic        rw,
    input wire logic [31:0] addr,
    input wire logic [2:0]  fc,
    input wire logic [1:0]  size,
    input wire logic [1:0]  async_ack,
    input wire logic        sync_term,
    input wire logic        bus_error_in,
    input wire logic        halt_line
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // a cycle ends only after some termination line was seen
    a_end_needs_term: assert property (
        $fell(addr_strobe) |-> $past(async_ack != 2'b00 || sync_term || bus_error_in))
        else $error("strobe dropped without termination");
    // a seen termination closes the cycle within the late window
    a_end_prompt: assert property (
        addr_strobe && (async_ack != 2'b00 || sync_term || bus_error_in)
        |-> ##[1:3] !addr_strobe)
        else $error("cycle not closed after termination");
    // halt alone never terminates a running cycle
    a_halt_no_end: assert property (
        addr_strobe && halt_line && async_ack == 2'b00 && !sync_term && !bus_error_in
        && $past(async_ack == 2'b00 && !sync_term && !bus_error_in) |=> addr_strobe)
        else $error("halt ended a cycle");
    // parked bus: no new strobe while halt has been standing
    a_halt_blocks: assert property (
        halt_line && $past(halt_line) && $past(halt_line, 2) && !addr_strobe
        && !$past(addr_strobe) |=> !addr_strobe)
        else $error("cycle started while halted");
    // retry keeps the access fields and reruns within a bounded wait
    a_retry_same: assert property (
        $fell(addr_strobe) && $past(bus_error_in && halt_line)
        |=> ($stable(addr) && $stable(fc) && $stable(size) && $stable(rw)) [*6])
        else $error("retry access fields changed");
    a_retry_rerun: assert property (
        $fell(addr_strobe) && $past(bus_error_in && halt_line) |-> ##[2:20] $rose(addr_strobe))
        else $error("retry not rerun");
    // the two termination kinds never meet in one cycle
    a_term_exclusive: assert property (
        !(sync_term && async_ack != 2'b00))
        else $error("sync and async termination together");
    // error released no earlier than acknowledge, halt no earlier than error
    a_error_drop: assert property (
        $fell(bus_error_in) |-> async_ack == 2'b00 && !sync_term)
        else $error("bus error released before acknowledge");
    a_halt_drop: assert property (
        $fell(halt_line) |-> !bus_error_in)
        else $error("halt released before bus error");
    // stale lines would end the next cycle early
    a_lines_clear: assert property (
        $rose(addr_strobe) |-> async_ack == 2'b00 && !sync_term && !bus_error_in)
        else $error("termination line left over at cycle start");
endmodule

/* File: testbench.sv */
`timescale 1ns/100ps
// ==========
// both ends joined; integer model predicts every response
module testbench;
    import bus_term_pkg::*;
    logic           ref_clk = 1'b0;
    logic           rst = 1'b1;
    logic           req_valid = 1'b0;
    logic           req_write = 1'b0;
    logic           req_prefetch = 1'b0;
    logic           req_walk = 1'b0;
    logic           prot_fault = 1'b0;
    logic           cfg_sync = 1'b0;
    logic           ecc_fail = 1'b0;
    logic           step_halt = 1'b0;
    logic [31:0]    req_addr = 32'h0000_0000;
    logic [31:0]    req_wdata = 32'h0000_0000;
    logic [2:0]     req_fc = 3'h1;
    logic [1:0]     req_size = 2'h0;
    ecc_policy_type ecc_policy = ECC_DELAY_RETRY;
    logic           req_ready, resp_valid, resp_error, resp_internal, resp_deferred;
    logic           exc_now, bus_halted, timeout_event;
    logic [31:0]    resp_rdata, got_data, s;
    logic [31:0]    seed = 32'h0000_ac4c;
    logic [31:0]    mem [16];
    logic [3:0]     got_flags;
    logic           to_seen = 1'b0;
    int unsigned    n_fail = 0;
    int unsigned    n_compared = 0;

    bus_term_if bus ();
    bus_term_device bus_term_device_inst (.ref_clk(ref_clk), .rst(rst), .bus(bus),
        .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
        .req_fc(req_fc), .req_size(req_size), .req_write(req_write), .req_wdata(req_wdata),
        .req_prefetch(req_prefetch), .req_walk(req_walk), .prot_fault(prot_fault),
        .resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_error(resp_error),
        .resp_internal(resp_internal), .resp_deferred(resp_deferred), .exc_now(exc_now),
        .bus_halted(bus_halted));
    bus_term_responder bus_term_responder_inst (.ref_clk(ref_clk), .rst(rst), .bus(bus),
        .cfg_sync(cfg_sync), .ecc_fail(ecc_fail), .ecc_policy(ecc_policy),
        .step_halt(step_halt), .timeout_event(timeout_event));
    bus_term_props bus_term_props_inst (.ref_clk(ref_clk), .rst(rst),
        .addr_strobe(bus.addr_strobe), .rw(bus.rw), .addr(bus.addr), .fc(bus.fc),
        .size(bus.size), .async_ack(bus.async_ack), .sync_term(bus.sync_term),
        .bus_error_in(bus.bus_error_in), .halt_line(bus.halt_line));

    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;
    // watchdog pulse stands one cycle only, so latch it
    always @(posedge ref_clk) if (timeout_event === 1'b1) to_seen <= 1'b1;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one request; held until ready was seen, so refusal loses nothing
    task automatic access(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                          input logic pf, input logic wk, input logic pr);
        int k;
        logic [31:0] fld;
        @(negedge ref_clk);
        req_addr = a;
        req_write = wr;
        req_wdata = wd;
        req_prefetch = pf;
        req_walk = wk;
        prot_fault = pr;
        req_valid = 1'b1;
        k = 0;
        while (req_ready !== 1'b1 && k < 200) begin
            @(negedge ref_clk);
            k++;
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
        // fields the strobe must carry, on a rerun as well
        fld = {!wr, req_fc, req_size, a[25:0]};
        k = 0;
        while (resp_valid !== 1'b1 && k < 200) begin
            // the rerun after a retry must read clean data
            if (bus.halt_line === 1'b1) ecc_fail = 1'b0;
            if (bus.addr_strobe === 1'b1) begin
                check({bus.rw, bus.fc, bus.size, bus.addr[25:0]}, fld);
            end
            @(negedge ref_clk);
            k++;
        end
        check({31'h0, resp_valid}, 32'h1);
        got_data = resp_rdata;
        got_flags = {resp_error, resp_internal, resp_deferred, exc_now};
    endtask

    // model: data from the word array, flags from the fault kind
    task automatic op(input logic [31:0] a, input logic wr, input logic pf, input logic wk,
                      input logic pr, input logic ecc);
        logic [31:0] wd;
        logic [31:0] ed;
        logic        err;
        wd = rnd();
        err = pr || a >= 32'h0000_0040;
        err = err || (ecc && (ecc_policy == ECC_DELAY_ERROR || ecc_policy == ECC_EARLY_ERROR));
        ed = (err || wr) ? 32'h0000_0000 : mem[a[5:2]];
        ecc_fail = ecc;
        access(a, wr, wd, pf, wk, pr);
        ecc_fail = 1'b0;
        if (wr && !err) mem[a[5:2]] = wd;
        check(got_data, ed);
        check({28'h0, got_flags}, {28'h0, err, pr || (wk && err), err && pf, err && !pf});
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        // fill every word, then random traffic on both termination kinds
        for (int i = 0; i < 16; i++) begin
            cfg_sync = i[0];
            op({26'h0, i[3:0], 2'b00}, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        end
        for (int i = 0; i < 24; i++) begin
            s = rnd();
            cfg_sync = s[8];
            req_fc = s[11:9];
            req_size = s[13:12];
            op({26'h0, s[3:0], 2'b00}, s[4], s[5], 1'b0, 1'b0, 1'b0);
        end
        // unmapped space: plain, prefetch and table-search accesses
        for (int i = 0; i < 2; i++) begin
            cfg_sync = i[0];
            op(32'h0000_1000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            op(32'h0000_1000, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
            op(32'h0000_1000, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        end
        check({31'h0, to_seen}, 32'h1);
        op(32'h0000_0008, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        // every correction policy on both cycle kinds
        for (int i = 0; i < 8; i++) begin
            cfg_sync = i[0];
            ecc_policy = ecc_policy_type'(i[2:1]);
            op({26'h0, i[3:0], 2'b00}, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        end
        // halt raised mid-cycle: normal end, then the bus stays parked
        for (int i = 0; i < 2; i++) begin
            cfg_sync = i[0];
            fork
                op(32'h0000_0010, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
                begin
                    wait (bus.addr_strobe === 1'b1);
                    @(negedge ref_clk);
                    step_halt = 1'b1;
                end
            join
            repeat (4) @(negedge ref_clk);
            check({30'h0, bus_halted, req_ready}, 32'h2);
            fork
                op(32'h0000_0014, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
                begin
                    repeat (5) @(negedge ref_clk);
                    check({31'h0, bus.addr_strobe}, 32'h0);
                    step_halt = 1'b0;
                end
            join
        end
        test_done();
    end

    // cuts a hung handshake short
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        test_done();
    end
endmodule
